// ==== src_top.sv ====
// Standby entry, wake-up, stabilisation and reset sources controller
`timescale 1ns/10ps
`default_nettype none
module src_top #(
  parameter int unsigned BOOT_CYC = src_pkg::BOOT_WAIT_CYC,
  parameter int unsigned WDT_LEN  = src_pkg::WDT_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        STBY_EXEC,
  input  wire logic        STBY_DEEP,
  input  wire logic [3:0]  STBY_OPERAND,
  input  wire logic [7:0]  REQ_FLAGS,
  input  wire logic [7:0]  SRC_ENABLES,
  input  wire logic        GLOBAL_UNMASK,
  input  wire logic [2:0]  STACK_PTR,
  input  wire logic [3:0]  WAKE_PORT_A,
  input  wire logic [3:0]  WAKE_PORT_B,
  input  wire logic [7:0]  WAKE_DIR_OUT,
  input  wire logic        RESET_PIN_B,
  output var  logic        STBY_ACTIVE,
  output var  logic        NOP_DONE,
  output var  logic        RESUME_NEXT,
  output var  logic        RESUME_VECTOR,
  output var  logic        TIMER_FLAG_CLR,
  output var  logic        TIMER_RESTART,
  output var  logic        WATCH_RUN,
  output var  logic        MAIN_OSC_EN,
  output var  logic        CORE_RESET,
  output var  logic        PC_CLEAR,
  output var  logic        PERIPH_INIT,
  output var  logic        RAM_HELD,
  output var  logic [15:0] DATA_BUFFER_WORD,
  output var  logic [7:0]  TIMER_ZERO_MODULO,
  output var  logic        HANG_DETECT_OUTPUT_B
);
  src_pkg::src_state_t state_r, state_nxt;
  logic [7:0]  pins_s;
  logic        rpin_s;
  logic [3:0]  op_r;
  logic        system_clock_select_r;
  logic        reload_r;
  logic        pinwk_r;
  logic        vec_pend_r;
  logic [9:0]  pre_r;
  logic [7:0]  tz_cnt_r;
  logic [31:0] rlow_r;
  logic [31:0] boot_r;
  logic [31:0] wdt_r;
  logic        wdt_exp;
  logic        sp_bad;
  logic [7:0]  pend_en;
  logic        tz_req;
  logic        pin_wake;
  logic        pins_ok;
  logic        rst_hit;
  logic        stab_done;
  logic        entry_ok;
  logic        wake;
  logic        wake_vec;
  logic        wake_pin;
  logic        wr_go;
  logic        rd_go;

  // Pins cross into the clock domain before anything looks at them
  src_sync #(.W(8), .RST_VAL(8'hFF)) u_pins (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     ({WAKE_PORT_B, WAKE_PORT_A}),
    .q     (pins_s)
  );
  src_sync #(.W(1), .RST_VAL(8'h01)) u_rpin (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     (RESET_PIN_B),
    .q     (rpin_s)
  );

  function automatic logic any_pend(input logic [7:0] req, input logic [7:0] en,
                                    input logic [7:0] mask);
    any_pend = |(req & en & mask);
  endfunction

  assign pend_en  = REQ_FLAGS & SRC_ENABLES;
  assign tz_req   = REQ_FLAGS[src_pkg::FLG_TM0];
  assign pin_wake = |(~pins_s | WAKE_DIR_OUT);
  assign pins_ok  = &(pins_s & ~WAKE_DIR_OUT);
  assign rst_hit  = (rlow_r >= 32'(src_pkg::RST_PIN_CYC));
  assign stab_done = (pre_r == src_pkg::PRE_LAST) && (tz_cnt_r == TIMER_ZERO_MODULO);
  assign wdt_exp  = (wdt_r == WDT_LEN - 1);
  assign sp_bad   = (state_r == src_pkg::ST_RUN) &&
                    (STACK_PTR == src_pkg::SP_OVER || STACK_PTR == src_pkg::SP_UNDER);

  // Entry checks; anything else, including other operands, is refused
  always_comb begin
    entry_ok = 1'b0;
    if (STBY_DEEP) begin
      entry_ok = system_clock_select_r && (STBY_OPERAND == src_pkg::OP_ANY) && pins_ok &&
                 !any_pend(REQ_FLAGS, SRC_ENABLES, src_pkg::DEEP_SRC_MASK);
    end else begin
      case (STBY_OPERAND)
        src_pkg::OP_TZ:   entry_ok = !tz_req;
        src_pkg::OP_ANY:  entry_ok = !(|pend_en) && pins_ok;
        src_pkg::OP_BOTH: entry_ok = !tz_req && !(|pend_en);
        default:          entry_ok = 1'b0;
      endcase
    end
  end

  // Wake decision and the way execution resumes
  always_comb begin
    wake     = 1'b0;
    wake_vec = 1'b0;
    wake_pin = 1'b0;
    if (state_r == src_pkg::ST_DEEP) begin
      if (pin_wake) begin
        wake     = 1'b1;
        wake_pin = 1'b1;
      end else if (any_pend(REQ_FLAGS, SRC_ENABLES, src_pkg::DEEP_SRC_MASK)) begin
        wake     = 1'b1;
        wake_vec = GLOBAL_UNMASK;
      end
    end else if (state_r == src_pkg::ST_LIGHT) begin
      case (op_r)
        src_pkg::OP_TZ: begin
          wake     = tz_req;
          wake_vec = GLOBAL_UNMASK;
        end
        src_pkg::OP_ANY: begin
          if (pin_wake) begin
            wake     = 1'b1;
            wake_pin = 1'b1;
          end else begin
            wake     = |pend_en;
            wake_vec = GLOBAL_UNMASK;
          end
        end
        src_pkg::OP_BOTH: begin
          wake     = tz_req || (|pend_en);
          wake_vec = GLOBAL_UNMASK;
        end
        default: wake = 1'b1;
      endcase
    end
  end

  // Main sequencer; the reset pin overrides every other state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      src_pkg::ST_RUN:
        if (STBY_EXEC && entry_ok) begin
          state_nxt = STBY_DEEP ? src_pkg::ST_DEEP : src_pkg::ST_LIGHT;
        end
      src_pkg::ST_LIGHT:
        if (wake) begin
          state_nxt = src_pkg::ST_RUN;
        end
      src_pkg::ST_DEEP:
        if (wake) begin
          state_nxt = src_pkg::ST_STAB;
        end
      src_pkg::ST_STAB:
        if (stab_done) begin
          state_nxt = src_pkg::ST_RUN;
        end
      src_pkg::ST_RST:
        if (rpin_s) begin
          state_nxt = src_pkg::ST_BOOT;
        end
      src_pkg::ST_BOOT:
        if (boot_r == BOOT_CYC - 1) begin
          state_nxt = src_pkg::ST_RUN;
        end
      default: state_nxt = src_pkg::ST_RST;
    endcase
    if (rst_hit) begin
      state_nxt = src_pkg::ST_RST;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state_r <= src_pkg::ST_RST;
      op_r    <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (STBY_EXEC && state_r == src_pkg::ST_RUN) begin
        op_r <= STBY_OPERAND;
      end
    end
  end

  // Reset pin low-time filter, cleared by any high sample
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || rpin_s) begin
      rlow_r <= 32'h0000_0000;
    end else if (!rst_hit) begin
      rlow_r <= rlow_r + 32'h0000_0001;
    end
  end

  // Oscillator start-up wait after reset release
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || state_r != src_pkg::ST_BOOT) begin
      boot_r <= 32'h0000_0000;
    end else begin
      boot_r <= boot_r + 32'h0000_0001;
    end
  end

  // Stabilisation: prescaler of 1024 feeding the timer zero count
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || state_r != src_pkg::ST_STAB) begin
      pre_r    <= 10'h000;
      tz_cnt_r <= 8'h00;
    end else if (pre_r == src_pkg::PRE_LAST) begin
      pre_r    <= 10'h000;
      tz_cnt_r <= tz_cnt_r + 8'h01;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // Watchdog holds its count in deep standby on main clock and resumes after
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || state_r == src_pkg::ST_RST || reload_r || wdt_exp) begin
      wdt_r <= 32'h0000_0000;
    end else if (state_r != src_pkg::ST_DEEP || !system_clock_select_r) begin
      wdt_r <= wdt_r + 32'h0000_0001;
    end
  end

  // Resume handshake towards the core
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      NOP_DONE       <= 1'b0;
      RESUME_NEXT    <= 1'b0;
      RESUME_VECTOR  <= 1'b0;
      TIMER_FLAG_CLR <= 1'b0;
      TIMER_RESTART  <= 1'b0;
      vec_pend_r     <= 1'b0;
      pinwk_r        <= 1'b0;
      STBY_ACTIVE    <= 1'b0;
    end else begin
      NOP_DONE       <= STBY_EXEC && state_r == src_pkg::ST_RUN && !entry_ok && !rst_hit;
      TIMER_FLAG_CLR <= state_r == src_pkg::ST_DEEP && wake && !rst_hit;
      TIMER_RESTART  <= state_r == src_pkg::ST_DEEP && wake && !rst_hit;
      STBY_ACTIVE    <= state_nxt != src_pkg::ST_RUN;
      if (wake) begin
        vec_pend_r <= wake_vec;
        pinwk_r    <= wake_pin;
      end
      RESUME_NEXT   <= 1'b0;
      RESUME_VECTOR <= 1'b0;
      if (!rst_hit && state_r == src_pkg::ST_LIGHT && wake) begin
        RESUME_NEXT   <= !wake_vec;
        RESUME_VECTOR <= wake_vec;
      end else if (!rst_hit && state_r == src_pkg::ST_STAB && stab_done) begin
        RESUME_NEXT   <= !vec_pend_r;
        RESUME_VECTOR <= vec_pend_r;
      end
    end
  end

  // Reset-source outputs and initialisation values
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      CORE_RESET           <= 1'b1;
      PC_CLEAR             <= 1'b1;
      PERIPH_INIT          <= 1'b1;
      MAIN_OSC_EN          <= 1'b0;
      WATCH_RUN            <= 1'b0;
      HANG_DETECT_OUTPUT_B <= 1'b1;
      DATA_BUFFER_WORD     <= src_pkg::DBF_RST;
      RAM_HELD             <= 1'b0;
    end else begin
      CORE_RESET  <= state_nxt == src_pkg::ST_RST || state_nxt == src_pkg::ST_BOOT;
      PERIPH_INIT <= state_nxt == src_pkg::ST_RST;
      MAIN_OSC_EN <= state_nxt != src_pkg::ST_RST &&
                     !(state_nxt == src_pkg::ST_DEEP && system_clock_select_r);
      WATCH_RUN   <= state_nxt != src_pkg::ST_RST &&
                     (state_nxt != src_pkg::ST_DEEP || !system_clock_select_r);
      HANG_DETECT_OUTPUT_B <= !(wdt_exp || sp_bad);
      PC_CLEAR    <= wdt_exp || sp_bad || state_nxt == src_pkg::ST_RST;
      if (state_nxt == src_pkg::ST_RST) begin
        DATA_BUFFER_WORD <= src_pkg::DBF_RST;
      end
      // Memory survives a pin reset only when it lands in standby
      if (state_nxt == src_pkg::ST_RST && state_r != src_pkg::ST_RST) begin
        RAM_HELD <= state_r == src_pkg::ST_LIGHT || state_r == src_pkg::ST_DEEP;
      end
    end
  end

  // AXI4-Lite slave: one outstanding write and one read
  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= src_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= wr_go;
      S_AXI_WREADY  <= wr_go;
      if (S_AXI_AWREADY) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (S_AXI_AWADDR == src_pkg::REG_CTRL ||
                         S_AXI_AWADDR == src_pkg::REG_TZMOD) ?
                        src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Writable control; the reload bit only pulses and reads back as zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      system_clock_select_r           <= src_pkg::CTRL_SYSTEM_CLOCK_SELECT_RST;
      reload_r          <= 1'b0;
      TIMER_ZERO_MODULO <= src_pkg::TZMOD_RST;
    end else begin
      reload_r <= 1'b0;
      if (state_nxt == src_pkg::ST_RST) begin
        system_clock_select_r           <= src_pkg::CTRL_SYSTEM_CLOCK_SELECT_RST;
        TIMER_ZERO_MODULO <= src_pkg::TZMOD_RST;
      end else if (S_AXI_AWREADY && S_AXI_WSTRB[0]) begin
        if (S_AXI_AWADDR == src_pkg::REG_CTRL) begin
          system_clock_select_r  <= S_AXI_WDATA[src_pkg::CTRL_SYSTEM_CLOCK_SELECT];
          reload_r <= S_AXI_WDATA[src_pkg::CTRL_RELOAD];
        end
        if (S_AXI_AWADDR == src_pkg::REG_TZMOD) begin
          TIMER_ZERO_MODULO <= S_AXI_WDATA[7:0];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= src_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= rd_go;
      if (rd_go) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= src_pkg::RESP_OKAY;
        S_AXI_RDATA  <= 32'h0000_0000;
        case (S_AXI_ARADDR)
          src_pkg::REG_CTRL:   S_AXI_RDATA[src_pkg::CTRL_SYSTEM_CLOCK_SELECT] <= system_clock_select_r;
          src_pkg::REG_TZMOD:  S_AXI_RDATA[7:0] <= TIMER_ZERO_MODULO;
          src_pkg::REG_STATUS: begin
            S_AXI_RDATA[src_pkg::STAT_STATE +: 3] <= state_r;
            S_AXI_RDATA[src_pkg::STAT_HELD]       <= RAM_HELD;
            S_AXI_RDATA[src_pkg::STAT_PINWK]      <= pinwk_r;
          end
          default: S_AXI_RRESP <= src_pkg::RESP_SLVERR;
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Helper: cycles spent in stabilisation
  logic [19:0] stab_cyc_r;
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || state_r != src_pkg::ST_STAB) begin
      stab_cyc_r <= 20'h0_0001;
    end else begin
      stab_cyc_r <= stab_cyc_r + 20'h0_0001;
    end
  end

  a_subclk_nop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_RUN && STBY_EXEC && STBY_DEEP && !system_clock_select_r && !rst_hit
    |=> NOP_DONE && state_r == src_pkg::ST_RUN)
    else $error("deep standby entered on subclock");
  a_light_tz_gate: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_RUN && STBY_EXEC && !STBY_DEEP &&
    STBY_OPERAND == src_pkg::OP_TZ && tz_req && !rst_hit |=> NOP_DONE ##1 !NOP_DONE)
    else $error("light 02H entered with timer request set");
  a_light_tz_wake: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_LIGHT && op_r == src_pkg::OP_TZ && tz_req && !rst_hit
    |=> state_r == src_pkg::ST_RUN && (RESUME_NEXT != RESUME_VECTOR))
    else $error("timer zero request did not end light standby");
  a_deep_exit: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_DEEP && wake && !rst_hit
    |=> TIMER_FLAG_CLR && TIMER_RESTART && state_r == src_pkg::ST_STAB)
    else $error("deep exit did not clear and restart timers");
  a_stab_length: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_STAB && state_nxt == src_pkg::ST_RUN
    |-> stab_cyc_r == 20'({12'h000, TIMER_ZERO_MODULO} + 20'h0_0001) * 20'h0_0400)
    else $error("stabilisation wait has wrong length");
  a_pin_resume: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_LIGHT && op_r == src_pkg::OP_ANY && pin_wake && !rst_hit
    |=> RESUME_NEXT && !RESUME_VECTOR)
    else $error("pin wake did not resume in line");
  a_irq_vector: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_LIGHT && op_r == src_pkg::OP_ANY && !pin_wake &&
    |pend_en && !rst_hit |=> RESUME_VECTOR == $past(GLOBAL_UNMASK))
    else $error("request wake resumed the wrong way");
  a_stack_hang: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sp_bad |=> !HANG_DETECT_OUTPUT_B && PC_CLEAR)
    else $error("stack fault not reported");
  a_reset_osc: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_RST |-> !MAIN_OSC_EN && PERIPH_INIT &&
    DATA_BUFFER_WORD == src_pkg::DBF_RST)
    else $error("reset state outputs wrong");
  a_deep_gate: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_RUN && STBY_EXEC && STBY_DEEP && !pins_ok && !rst_hit
    |=> NOP_DONE && state_r == src_pkg::ST_RUN)
    else $error("deep entered with a wake pin active");
  c_light: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_LIGHT ##1 RESUME_VECTOR);
  c_deep: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    state_r == src_pkg::ST_STAB ##1 state_r == src_pkg::ST_RUN);
  c_wdt: cover property (@(posedge REF_CLK) disable iff (!RST_B) wdt_exp);
endmodule
`default_nettype wire

// ==== src_pkg.sv ====
// Shared constants and types for the standby and reset controller
package src_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_TZMOD  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Control register fields
  localparam int CTRL_SYSTEM_CLOCK_SELECT  = 0;
  localparam int CTRL_RELOAD = 1;
  localparam logic CTRL_SYSTEM_CLOCK_SELECT_RST = 1'b1;
  // Status register fields
  localparam int STAT_STATE = 0;
  localparam int STAT_HELD  = 3;
  localparam int STAT_PINWK = 4;
  // Request and enable flag positions
  localparam int FLG_ENV  = 0;
  localparam int FLG_TM2  = 1;
  localparam int FLG_TM0  = 2;
  localparam int FLG_TM1  = 3;
  localparam int FLG_EXT  = 4;
  localparam int FLG_WTM  = 5;
  localparam int FLG_SIO  = 6;
  localparam int FLG_XRAM = 7;
  // Sources that can end deep standby: envelope, timer one, pin, watch, serial
  localparam logic [7:0] DEEP_SRC_MASK = 8'h79;
  // Standby operands
  localparam logic [3:0] OP_TZ   = 4'h2;
  localparam logic [3:0] OP_ANY  = 4'h8;
  localparam logic [3:0] OP_BOTH = 4'hA;
  // Reset values, stack fault codes and response codes
  localparam logic [7:0]  TZMOD_RST = 8'hFF;
  localparam logic [15:0] DBF_RST   = 16'h0320;
  localparam logic [2:0]  SP_OVER   = 3'h6;
  localparam logic [2:0]  SP_UNDER  = 3'h7;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // Timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int CLK_NS          = 40;
  localparam int RST_PIN_MIN_NS  = 50_000;
  localparam int RST_PIN_CYC     = (RST_PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOOT_WAIT_MS    = 64;
  localparam int BOOT_WAIT_CYC   = BOOT_WAIT_MS * (CLK_HZ / 1000);
  localparam int WDT_MAX_MS      = 340;
  localparam int WDT_CYC         = WDT_MAX_MS * (CLK_HZ / 1000);
  localparam int STAB_PRESCALE   = 1024;
  localparam logic [9:0] PRE_LAST = 10'h3FF;
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_LIGHT = 3'b001,
    ST_DEEP  = 3'b010,
    ST_STAB  = 3'b011,
    ST_RST   = 3'b100,
    ST_BOOT  = 3'b101
  } src_state_t;
endpackage

// ==== src_sync.sv ====
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module src_sync #(
  parameter int         W       = 1,
  parameter logic [7:0] RST_VAL = 8'hFF
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= RST_VAL[W-1:0];
      q      <= RST_VAL[W-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== src_core_model.sv ====
// Core, request flags and wake pins facing the standby controller
`timescale 1ns/10ps
`default_nettype none
module src_core_model (
  input  wire logic       clk,
  input  wire logic       flag_clr,
  output var  logic       exec,
  output var  logic       deep,
  output var  logic [3:0] op,
  output var  logic [7:0] req,
  output var  logic [7:0] en,
  output var  logic       unmask,
  output var  logic [2:0] sp,
  output var  logic [7:0] pins,
  output var  logic [7:0] dir
);
  initial begin
    {exec, deep, op, req, en, unmask, sp, dir} = '0;
    pins = 8'hFF;
  end
  // Timer flags drop on deep exit, like the real flag logic
  always @(posedge clk) if (flag_clr) req <= req & 8'hF1;
  // Only listed operands, unless the bench asks for a refusal
  task automatic issue(input logic d, input logic [3:0] o);
    @(posedge clk);
    exec <= 1'b1;
    deep <= d;
    op   <= o;
    @(posedge clk);
    exec <= 1'b0;
  endtask
  task automatic put(input logic [7:0] r, input logic [7:0] e, input logic u,
                     input logic [7:0] p);
    @(posedge clk);
    req    <= r;
    en     <= e;
    unmask <= u;
    pins   <= p;
  endtask
endmodule
`default_nettype wire

// ==== standby_and_reset_control_bench.sv ====
// Self-checking bench for the standby and reset controller
`timescale 1ns/10ps
`default_nettype none
module standby_and_reset_control_bench;
  logic REF_CLK, RST_B, RESET_PIN_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, STBY_EXEC, STBY_DEEP, GLOBAL_UNMASK, STBY_ACTIVE;
  logic NOP_DONE, RESUME_NEXT, RESUME_VECTOR, TIMER_FLAG_CLR, TIMER_RESTART, WATCH_RUN;
  logic MAIN_OSC_EN, CORE_RESET, PC_CLEAR, PERIPH_INIT, RAM_HELD, HANG_DETECT_OUTPUT_B;
  logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR, STBY_OPERAND;
  wire logic [3:0] WAKE_PORT_A, WAKE_PORT_B;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic [7:0] REQ_FLAGS, SRC_ENABLES, WAKE_DIR_OUT, TIMER_ZERO_MODULO;
  logic [2:0] STACK_PTR, e3;
  logic [2:0] exp_q[$];
  logic [15:0] DATA_BUFFER_WORD;
  logic u, clr_seen;
  int n_fail, n_compared, k;
  src_top #(.BOOT_CYC(20), .WDT_LEN(50)) src_top_i (.REF_CLK, .RST_B, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .STBY_EXEC, .STBY_DEEP,
    .STBY_OPERAND, .REQ_FLAGS, .SRC_ENABLES, .GLOBAL_UNMASK, .STACK_PTR, .WAKE_PORT_A,
    .WAKE_PORT_B, .WAKE_DIR_OUT, .RESET_PIN_B, .STBY_ACTIVE, .NOP_DONE, .RESUME_NEXT,
    .RESUME_VECTOR, .TIMER_FLAG_CLR, .TIMER_RESTART, .WATCH_RUN, .MAIN_OSC_EN, .CORE_RESET,
    .PC_CLEAR, .PERIPH_INIT, .RAM_HELD, .DATA_BUFFER_WORD, .TIMER_ZERO_MODULO,
    .HANG_DETECT_OUTPUT_B);
  src_core_model src_core_model_i (.clk(REF_CLK), .flag_clr(TIMER_FLAG_CLR),
    .exec(STBY_EXEC), .deep(STBY_DEEP), .op(STBY_OPERAND), .req(REQ_FLAGS),
    .en(SRC_ENABLES), .unmask(GLOBAL_UNMASK), .sp(STACK_PTR),
    .pins({WAKE_PORT_B, WAKE_PORT_A}), .dir(WAKE_DIR_OUT));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge REF_CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, v};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do @(posedge REF_CLK); while (S_AXI_AWREADY !== 1'b1);
    {S_AXI_AWVALID, S_AXI_WVALID} <= 2'h0;
    while (S_AXI_BVALID !== 1'b1) @(posedge REF_CLK);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge REF_CLK);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
    do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1) @(posedge REF_CLK);
    {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
  endtask
  // Queue the expected outcome, issue the stop, then wait three cycles; settle does the bounded wait
  task automatic run(input logic dp, input logic [3:0] o, input logic [2:0] e);
    exp_q.push_back(e);
    src_core_model_i.issue(dp, o);
    repeat (3) @(posedge REF_CLK);
  endtask
  task automatic settle;
    for (k = 0; k < 2000 && STBY_ACTIVE === 1'b1; k++) @(posedge REF_CLK);
    src_core_model_i.put(8'h00, 8'h00, 1'b0, 8'hFF);
  endtask
  // Each outcome pulse is matched against the oldest note
  always @(posedge REF_CLK) begin
    if (RST_B === 1'b1 && {NOP_DONE, RESUME_NEXT, RESUME_VECTOR} !== 3'h0) begin
      e3 = (exp_q.size() > 0) ? exp_q.pop_front() : 3'h0;
      check("outcome", 32'(e3), 32'({NOP_DONE, RESUME_NEXT, RESUME_VECTOR}));
    end
  end
  always @(posedge REF_CLK) if (TIMER_FLAG_CLR && TIMER_RESTART) clr_seen <= 1'b1;
  initial begin
    repeat (20000) @(posedge REF_CLK);
    n_fail++;
    results();
  end
  initial begin
    {RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, clr_seen} = '0;
    {S_AXI_WSTRB, RESET_PIN_B} = 5'h1F;
    void'($urandom(49));
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    check("dbf", 32'h0000_0320, 32'(DATA_BUFFER_WORD));
    for (k = 0; k < 100 && CORE_RESET !== 1'b0; k++) @(posedge REF_CLK);
    check("boot", 32'h0000_0001, 32'(k >= 20));
    axr(src_pkg::REG_TZMOD);
    check("modulo", 32'h0000_00FF, d);
    axr(4'hC);
    check("rd unmapped", {30'h0, src_pkg::RESP_SLVERR}, {d[29:0], r});
    axw(4'hC, 32'h0000_0000);
    check("wr unmapped", 32'(src_pkg::RESP_SLVERR), 32'(r));
    axw(src_pkg::REG_CTRL, 32'h0000_0000);
    run(1'b1, src_pkg::OP_ANY, 3'h4);
    axw(src_pkg::REG_CTRL, 32'h0000_0001);
    src_core_model_i.put(8'h04, 8'h00, 1'b0, 8'hFF);
    run(1'b0, src_pkg::OP_TZ, 3'h4);
    src_core_model_i.put(8'h40, 8'h40, 1'b0, 8'hFF);
    run(1'b0, src_pkg::OP_ANY, 3'h4);
    run(1'b0, src_pkg::OP_BOTH, 3'h4);
    u = 1'($urandom % 2);
    src_core_model_i.put(8'h00, 8'h00, u, 8'hFF);
    run(1'b0, src_pkg::OP_TZ, u ? 3'h1 : 3'h2);
    check("light", 32'h0000_0001, 32'(STBY_ACTIVE));
    src_core_model_i.put(8'h04, 8'h00, u, 8'hFF);
    settle();
    src_core_model_i.put(8'h00, 8'h40, 1'b1, 8'hFF);
    run(1'b0, src_pkg::OP_ANY, 3'h2);
    src_core_model_i.put(8'h00, 8'h40, 1'b1, ~(8'h01 << ($urandom % 8)));
    settle();
    src_core_model_i.put(8'h00, 8'h40, u, 8'hFF);
    run(1'b0, src_pkg::OP_ANY, u ? 3'h1 : 3'h2);
    src_core_model_i.put(8'h40, 8'h40, u, 8'hFF);
    settle();
    src_core_model_i.put(8'h00, 8'h40, 1'b1, 8'hFF);
    run(1'b0, src_pkg::OP_BOTH, 3'h1);
    src_core_model_i.put(8'h20, 8'h40, 1'b1, 8'hFF);
    repeat (6) @(posedge REF_CLK);
    check("masked wake", 32'h0000_0001, 32'(STBY_ACTIVE));
    src_core_model_i.put(8'h60, 8'h40, 1'b1, 8'hFF);
    settle();
    // Pin low must reach the synchroniser output before the stop is tried
    src_core_model_i.put(8'h00, 8'h01, 1'b0, 8'hFE);
    repeat (2) @(posedge REF_CLK);
    run(1'b1, src_pkg::OP_ANY, 3'h4);
    src_core_model_i.put(8'h00, 8'h01, 1'b0, 8'hFF);
    axw(src_pkg::REG_TZMOD, 32'h0000_0000);
    run(1'b1, src_pkg::OP_ANY, 3'h2);
    check("deep clocks", 32'h0000_0000, 32'({MAIN_OSC_EN, WATCH_RUN}));
    src_core_model_i.put(8'h05, 8'h01, 1'b0, 8'hFF);
    settle();
    check("stabilise", 32'h0000_0001, 32'(k >= 1024 && k <= 1030));
    check("deep exit", 32'h0000_0001, 32'(clr_seen));
    check("watch run", 32'h0000_0001, 32'(WATCH_RUN));
    axw(src_pkg::REG_CTRL, 32'h0000_0003);
    src_core_model_i.sp <= src_pkg::SP_OVER;
    for (k = 0; k < 6 && HANG_DETECT_OUTPUT_B !== 1'b0; k++) @(posedge REF_CLK);
    check("stack", 32'h0000_0001, 32'(k < 6));
    src_core_model_i.sp <= 3'h0;
    axw(src_pkg::REG_CTRL, 32'h0000_0003);
    for (k = 0; k < 200 && HANG_DETECT_OUTPUT_B !== 1'b0; k++) @(posedge REF_CLK);
    check("watchdog", 32'h0000_0001, 32'(k >= 40 && k <= 55));
    RESET_PIN_B <= 1'b0;
    repeat (1300) @(posedge REF_CLK);
    check("pin reset", 32'h0000_000E,
          32'({CORE_RESET, PC_CLEAR, PERIPH_INIT, MAIN_OSC_EN}));
    check("modulo rst", 32'h0000_00FF, 32'(TIMER_ZERO_MODULO));
    check("ram held", 32'h0000_0000, 32'(RAM_HELD));
    RESET_PIN_B <= 1'b1;
    for (k = 0; k < 100 && CORE_RESET !== 1'b0; k++) @(posedge REF_CLK);
    check("restart", 32'h0000_0001, 32'(k >= 20 && MAIN_OSC_EN === 1'b1));
    check("notes left", 32'h0000_0000, exp_q.size());
    results();
  end
endmodule
`default_nettype wire
